// ===== design/fcp_cfg.svh
/*
   Constants of the port primitive sequence state machine: recognition run,
   idle burst on entering the active state, timer widths and the event timeout.
   Assumes a 100 MHz word clock; times are turned into cycles by the port module's TIMEOUT_CYC default.
*/
`ifndef FCP_CFG_SVH
`define FCP_CFG_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define FCP_CLK_HZ      100000000
`define FCP_RTTOV_MS    100
`define FCP_TIMER_W     24

// ----------------------------------------------------------------
// word counts
// ----------------------------------------------------------------
`define FCP_REC_LAST    2'h2
`define FCP_MIN_IDLES   3'h6
`define FCP_ERR_W       16
`define FCP_ERR_MAX     16'hffff

`endif

// ===== design/fcp_pkg.sv
/*
   Types shared by the port state machine and its sequence recogniser.
   Assumes nothing beyond the constants header.
*/
package fcp_pkg;

   // ----------------------------------------------------------------
   // received word classes, as decoded by the link receiver
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {RX_OTHER, RX_IDLE, RX_LR, RX_LRR, RX_OLS, RX_NOS} rx_code_t;

   // ----------------------------------------------------------------
   // port states and transmitted word classes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {AC, LR1, LR2, LR3, LF1, LF2, OL1, OL2, OL3} port_state_t;
   typedef enum logic [2:0] {TX_FILL, TX_IDLE, TX_LR, TX_LRR, TX_OLS, TX_NOS} tx_word_t;

   // ----------------------------------------------------------------
   // register images
   // ----------------------------------------------------------------
   typedef struct packed {
      rx_code_t    last;
      logic [1:0]  run;
      logic        valid;
   } rec_state_t;

   typedef struct packed {
      port_state_t st;
      tx_word_t    tx;
      logic [2:0]  idleLeft;
      logic [23:0] timer;
      logic        protoErr;
      logic [15:0] errCnt;
      logic        pulseMode;
      logic        leaveNormal;
   } fsm_state_t;

endpackage : fcp_pkg

// ===== design/link_port_primitive_sequence_fsm.sv
/*
   Normal-operation port state machine of a serial link port: chooses the
   word class to send and follows received LR, LRR, Idle, OLS and NOS.
   Assumes a word decoder upstream giving one word class per clock, and
   that loss of signal, qualified loss of sync, link timeout, link reset
   and restart requests come from surrounding logic, synchronous to sys_clk.
*/
// Contract
// - each state sends its own word: fill, LR, LRR, Idle, OLS or NOS
// - received LR goes to LR2, but LF2 from LF2 and OL3
// - received LRR goes to LR3 from AC, LR1-3, OL2; OL3 goes LF2
// - LRR in AC flags a protocol error and bumps the error count
// - received Idles go to AC from AC, LR2, LR3; others stay
// - received OLS goes to OL2 from any state
// - in OL1 all events are ignored until the port decides to leave
// - on entering AC send at least six Idles before anything else
// - LF1 timer runs once NOS is no longer recognised
// - OL2 timer runs once OLS is no longer recognised
// - OL1 timer runs while the port sends OLS trying to go online
// - transmitter may pulse on loss of signal
// - conditions not listed leave the state unchanged
// - with speed negotiation, loss of sync enters LF2 and leaves normal operation
`timescale 1ns/100ps
`default_nettype none
`include "fcp_cfg.svh"
module link_port_primitive_sequence_fsm #(
   parameter int unsigned TIMEOUT_CYC = `FCP_RTTOV_MS * (`FCP_CLK_HZ / 1000)
) (
   input  wire logic                sys_clk,          // word clock, 100 MHz
   input  wire logic                reset,            // synchronous, active high
   input  wire fcp_pkg::rx_code_t   rxCode,           // decoded received word class
   input  wire logic                lossOfSignal,     // receiver sees no signal
   input  wire logic                lossOfSync,       // sync lost longer than the receiver timeout
   input  wire logic                linkTimeout,      // link timeout expired
   input  wire logic                linkResetReq,     // start link reset from AC
   input  wire logic                restartReq,       // restart link: go to OL1
   input  wire logic                ol1Leave,         // port decides to leave OL1
   input  wire logic                speedNegSupport,  // speed negotiation or training supported
   input  wire logic                pulseEnable,      // laser safety allows pulsed mode
   output var  fcp_pkg::port_state_t portState,       // current state
   output var  fcp_pkg::tx_word_t   txWord,           // word class to send
   output var  logic                protoErr,         // protocol error pulse
   output var  logic [15:0]         protoErrCount,    // error count of the link_error_status_block
   output var  logic                pulseMode,        // transmitter in pulsed mode
   output var  logic                leaveNormal       // left normal operation
);
   fcp_pkg::fsm_state_t r;
   fcp_pkg::fsm_state_t n;

   logic recLR;
   logic recLRR;
   logic recIdle;
   logic recOLS;
   logic recNOS;
   logic runNow;
   logic evtTimeout;
   logic entering;
   logic quiet;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic isOffline(input fcp_pkg::port_state_t s);
      isOffline = (s == fcp_pkg::OL1) || (s == fcp_pkg::OL2) || (s == fcp_pkg::OL3);
   endfunction : isOffline

   function automatic fcp_pkg::tx_word_t txFor(input fcp_pkg::port_state_t s, input logic idling);
      unique case (s)
         fcp_pkg::AC:               txFor = idling ? fcp_pkg::TX_IDLE : fcp_pkg::TX_FILL;
         fcp_pkg::LR1, fcp_pkg::OL2: txFor = fcp_pkg::TX_LR;
         fcp_pkg::LR2:              txFor = fcp_pkg::TX_LRR;
         fcp_pkg::LR3:              txFor = fcp_pkg::TX_IDLE;
         fcp_pkg::LF1, fcp_pkg::OL1: txFor = fcp_pkg::TX_OLS;
         fcp_pkg::LF2, fcp_pkg::OL3: txFor = fcp_pkg::TX_NOS;
      endcase
   endfunction : txFor

   // ----------------------------------------------------------------
   // sequence recognition
   // ----------------------------------------------------------------
   seq_recog_if rif ();

   assign rif.rxCode = rxCode;

   seq_recognizer u_rec (
      .sys_clk (sys_clk),
      .reset   (reset),
      .rif     (rif)
   );

   assign recLR   = rif.recValid && (rif.recCode == fcp_pkg::RX_LR);
   assign recLRR  = rif.recValid && (rif.recCode == fcp_pkg::RX_LRR);
   assign recIdle = rif.recValid && (rif.recCode == fcp_pkg::RX_IDLE);
   assign recOLS  = rif.recValid && (rif.recCode == fcp_pkg::RX_OLS);
   assign recNOS  = rif.recValid && (rif.recCode == fcp_pkg::RX_NOS);

   // ----------------------------------------------------------------
   // event timer
   // ----------------------------------------------------------------
   // the count restarts whenever the state changes or the run condition drops
   assign runNow = (r.st == fcp_pkg::LR1) || (r.st == fcp_pkg::LR2) || (r.st == fcp_pkg::LR3)
                || ((r.st == fcp_pkg::LF1) && !recNOS)
                || ((r.st == fcp_pkg::OL2) && !recOLS)
                || (r.st == fcp_pkg::OL1);
   assign evtTimeout = runNow && (r.timer == `FCP_TIMER_W'(TIMEOUT_CYC - 1));

   assign quiet = !lossOfSync && !lossOfSignal && !evtTimeout && !linkTimeout
               && !((r.st == fcp_pkg::OL1) && !ol1Leave);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      n = r;
      n.protoErr  = 1'b0;
      n.pulseMode = lossOfSignal && pulseEnable;
      if ((r.st == fcp_pkg::OL1) && !ol1Leave) begin
         n.st = r.st;
      end else if (lossOfSync) begin
         if (speedNegSupport) begin
            n.st          = fcp_pkg::LF2;
            n.leaveNormal = 1'b1;
         end else begin
            n.st = isOffline(r.st) ? fcp_pkg::OL3 : fcp_pkg::LF2;
         end
      end else if (lossOfSignal || evtTimeout) begin
         n.st = isOffline(r.st) ? fcp_pkg::OL3 : fcp_pkg::LF2;
      end else if (linkTimeout) begin
         n.st = fcp_pkg::LR1;
      end else if (recNOS) begin
         n.st = fcp_pkg::LF1;
      end else if (recLR) begin
         if ((r.st == fcp_pkg::LF2) || (r.st == fcp_pkg::OL3)) begin
            n.st = fcp_pkg::LF2;
         end else begin
            n.st = fcp_pkg::LR2;
         end
      end else if (recLRR) begin
         if (r.st == fcp_pkg::OL3) begin
            n.st = fcp_pkg::LF2;
         end else if ((r.st == fcp_pkg::AC) || (r.st == fcp_pkg::LR1) || (r.st == fcp_pkg::LR2)
                   || (r.st == fcp_pkg::LR3) || (r.st == fcp_pkg::OL2)) begin
            n.st = fcp_pkg::LR3;
         end
         if (r.st == fcp_pkg::AC) begin
            n.protoErr = 1'b1;
         end
      end else if (recOLS) begin
         n.st = fcp_pkg::OL2;
      end else if (recIdle) begin
         if ((r.st == fcp_pkg::AC) || (r.st == fcp_pkg::LR2) || (r.st == fcp_pkg::LR3)) begin
            n.st = fcp_pkg::AC;
         end
      end else if (restartReq) begin
         n.st = fcp_pkg::OL1;
      end else if (linkResetReq && (r.st == fcp_pkg::AC)) begin
         n.st = fcp_pkg::LR1;
      end
      // any other condition keeps n.st == r.st

      // saturating so a stuck link cannot wrap the count back to a clean value
      if (n.protoErr && (r.errCnt != `FCP_ERR_MAX)) begin
         n.errCnt = r.errCnt + 16'h1;
      end

      // the count parks at expiry, so an OL1 timeout held off by the freeze still acts once the port leaves
      if (runNow && (n.st == r.st)) begin
         n.timer = evtTimeout ? r.timer : r.timer + `FCP_TIMER_W'(1);
      end else begin
         n.timer = '0;
      end

      entering = (n.st == fcp_pkg::AC) && (r.st != fcp_pkg::AC);
      if (entering) begin
         n.idleLeft = `FCP_MIN_IDLES - 3'h1;
      end else if ((n.st == fcp_pkg::AC) && (r.idleLeft != 3'h0)) begin
         n.idleLeft = r.idleLeft - 3'h1;
      end else begin
         n.idleLeft = 3'h0;
      end
      n.tx = txFor(n.st, entering || (r.idleLeft != 3'h0));
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         r <= '{st: fcp_pkg::OL1, tx: fcp_pkg::TX_OLS, default: '0};
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign portState     = r.st;
   assign txWord        = r.tx;
   assign protoErr      = r.protoErr;
   assign protoErrCount = r.errCnt;
   assign pulseMode     = r.pulseMode;
   assign leaveNormal   = r.leaveNormal;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   tx_map_a: assert property (
      (portState == fcp_pkg::LR1 |-> txWord == fcp_pkg::TX_LR)
      and (portState == fcp_pkg::LR2 |-> txWord == fcp_pkg::TX_LRR)
      and (portState == fcp_pkg::LF2 |-> txWord == fcp_pkg::TX_NOS)
      and (portState == fcp_pkg::OL1 |-> txWord == fcp_pkg::TX_OLS))
      else $error("transmitted word does not match state");

   tx_rest_a: assert property (
      (portState == fcp_pkg::LR3 |-> txWord == fcp_pkg::TX_IDLE)
      and (portState == fcp_pkg::LF1 |-> txWord == fcp_pkg::TX_OLS)
      and (portState == fcp_pkg::OL2 |-> txWord == fcp_pkg::TX_LR)
      and (portState == fcp_pkg::OL3 |-> txWord == fcp_pkg::TX_NOS))
      else $error("transmitted word does not match recovery or offline state");

   lr_to_lr2_a: assert property (
      quiet && recLR && !isOffline(portState) && portState != fcp_pkg::LF2
      |=> portState == fcp_pkg::LR2)
      else $error("received LR did not lead to LR2");

   lr_hold_lf2_a: assert property (
      quiet && recLR && (portState == fcp_pkg::LF2 || portState == fcp_pkg::OL3)
      |=> portState == fcp_pkg::LF2)
      else $error("received LR in LF2 or OL3 did not lead to LF2");

   lrr_to_lr3_a: assert property (
      quiet && recLRR && (portState == fcp_pkg::LR1 || portState == fcp_pkg::OL2)
      |=> portState == fcp_pkg::LR3)
      else $error("received LRR did not lead to LR3");

   ac_lrr_err_a: assert property (
      quiet && recLRR && portState == fcp_pkg::AC && protoErrCount != `FCP_ERR_MAX
      |=> protoErr && protoErrCount == $past(protoErrCount) + 16'h1)
      else $error("LRR in AC not counted as protocol error");

   idle_to_ac_a: assert property (
      quiet && recIdle && (portState == fcp_pkg::LR2 || portState == fcp_pkg::LR3)
      |=> portState == fcp_pkg::AC && txWord == fcp_pkg::TX_IDLE)
      else $error("entry to AC from Idles not seen");

   ols_to_ol2_a: assert property (
      quiet && recOLS |=> portState == fcp_pkg::OL2)
      else $error("received OLS did not lead to OL2");

   ol1_ignore_a: assert property (
      portState == fcp_pkg::OL1 && !ol1Leave |=> $stable(portState))
      else $error("OL1 reacted before leave decision");

   six_idles_a: assert property (
      portState != fcp_pkg::AC ##1 portState == fcp_pkg::AC
      |-> (txWord != fcp_pkg::TX_FILL) [*6])
      else $error("fewer than six idles after entering AC");

   lf1_timer_a: assert property (
      portState == fcp_pkg::LF1 && recNOS |=> r.timer == '0)
      else $error("LF1 timer ran while NOS recognised");

   ol2_timer_a: assert property (
      portState == fcp_pkg::OL2 && recOLS |=> r.timer == '0)
      else $error("OL2 timer ran while OLS recognised");

   ol1_timer_a: assert property (
      portState == fcp_pkg::OL1 && !ol1Leave && r.timer != `FCP_TIMER_W'(TIMEOUT_CYC - 1)
      |=> r.timer == $past(r.timer) + `FCP_TIMER_W'(1))
      else $error("OL1 timer not counting");

   pulse_mode_a: assert property (
      (lossOfSignal && pulseEnable |=> pulseMode)
      and (!(lossOfSignal && pulseEnable) |=> !pulseMode))
      else $error("pulsed mode does not follow loss of signal");

   stay_put_a: assert property (
      quiet && !rif.recValid && !restartReq && !linkResetReq |=> $stable(portState))
      else $error("state changed without a cause");

   sync_leave_a: assert property (
      lossOfSync && speedNegSupport && !(portState == fcp_pkg::OL1 && !ol1Leave)
      |=> portState == fcp_pkg::LF2 && leaveNormal)
      else $error("loss of sync did not leave normal operation");

   reach_ac_c:    cover property (portState == fcp_pkg::LR3 ##1 portState == fcp_pkg::AC);
   proto_err_c:   cover property (protoErr);
   ol1_out_c:     cover property (portState == fcp_pkg::OL1 ##1 portState == fcp_pkg::OL2);
   lf1_expire_c:  cover property (portState == fcp_pkg::LF1 ##1 portState == fcp_pkg::LF2);
   ol3_fail_c:    cover property (portState == fcp_pkg::OL3 ##1 portState == fcp_pkg::LF2);
endmodule : link_port_primitive_sequence_fsm
`default_nettype wire

// ===== design/seq_recog_if.sv
/*
   Carrier between the port state machine and the sequence recogniser.
   Assumes both ends run on the same word clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface seq_recog_if;
   fcp_pkg::rx_code_t rxCode;
   fcp_pkg::rx_code_t recCode;
   logic              recValid;

   modport rec (input rxCode, output recCode, output recValid);
   modport fsm (output rxCode, input recCode, input recValid);
endinterface : seq_recog_if
`default_nettype wire

// ===== design/seq_recognizer.sv
/*
   Primitive sequence recogniser: a received word class counts as recognised
   once it has been seen on consecutive words for the configured run.
   Assumes one decoded word class per clock, synchronous to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fcp_cfg.svh"
module seq_recognizer (
   input  wire logic  sys_clk,   // word clock
   input  wire logic  reset,     // synchronous, active high
   seq_recog_if.rec   rif        // word in, recognised class out
);
   fcp_pkg::rec_state_t r;
   fcp_pkg::rec_state_t n;

   // ----------------------------------------------------------------
   // run counter
   // ----------------------------------------------------------------
   always_comb begin
      n = r;
      n.last = rif.rxCode;
      if (rif.rxCode == r.last) begin
         if (r.run != `FCP_REC_LAST) begin
            n.run = r.run + 2'h1;
         end
      end else begin
         n.run = 2'h0;
      end
      // unknown words never form a sequence
      n.valid = (n.run == `FCP_REC_LAST) && (rif.rxCode != fcp_pkg::RX_OTHER);
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         r <= '{last: fcp_pkg::RX_OTHER, default: '0};
      end else begin
         r <= n;
      end
   end

   assign rif.recCode  = r.last;
   assign rif.recValid = r.valid;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   run_recog_a: assert property (@(posedge sys_clk) disable iff (reset)
      rif.recValid |-> $past(rif.rxCode, 1) == rif.recCode && $past(rif.rxCode, 2) == rif.recCode
                       && $past(rif.rxCode, 3) == rif.recCode)
      else $error("sequence recognised without a full run");
endmodule : seq_recognizer
`default_nettype wire

// ===== dv/far_port_model.sv
/*
   Behavioural far port: sends one decoded word class per clock.
   Assumes the bench either commands the class or lets the model answer
   the block's transmitted class the way a connected port would.
*/
`timescale 1ns/100ps
`default_nettype none
module far_port_model (
   input  wire logic               sys_clk,  // word clock
   input  wire logic               autoOn,   // answer the block instead of obeying cmdCode
   input  wire fcp_pkg::rx_code_t  cmdCode,  // commanded word class
   input  wire fcp_pkg::tx_word_t  txSeen,   // word class the block sends
   output var  fcp_pkg::rx_code_t  rxCode    // word class towards the block
);
   initial rxCode = fcp_pkg::RX_OTHER;

   // ----------------------------------------------------------------
   // word generation
   // ----------------------------------------------------------------
   // a sequence is repeated on every word so the far end can recognise it
   always @(posedge sys_clk) begin
      if (!autoOn) begin
         rxCode <= cmdCode;
      end else begin
         case (txSeen)
            fcp_pkg::TX_LR:   rxCode <= fcp_pkg::RX_LRR;   // answer a link reset
            fcp_pkg::TX_LRR:  rxCode <= fcp_pkg::RX_IDLE;  // reset answered, go idle
            fcp_pkg::TX_IDLE: rxCode <= fcp_pkg::RX_IDLE;
            default:          rxCode <= fcp_pkg::RX_OTHER;
         endcase
      end
   end
endmodule : far_port_model
`default_nettype wire

// ===== dv/link_port_primitive_sequence_fsm_tb.sv
/*
   Self-checking bench of the port state machine with a far port model.
   Assumes a 20-cycle event timeout and inputs driven at the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module link_port_primitive_sequence_fsm_tb;
   localparam int unsigned TMO = 20;
   logic sys_clk, reset, lossOfSignal, lossOfSync, linkTimeout, linkResetReq;
   logic restartReq, ol1Leave, speedNegSupport, pulseEnable, autoOn;
   logic protoErr, pulseMode, leaveNormal;
   logic [15:0] protoErrCount;
   fcp_pkg::rx_code_t rxCode, cmdCode;
   fcp_pkg::port_state_t portState;
   fcp_pkg::tx_word_t txWord;
   int badCount, comparisons, cycCnt;

   link_port_primitive_sequence_fsm #(.TIMEOUT_CYC(TMO)) uut (
      .sys_clk(sys_clk), .reset(reset), .rxCode(rxCode), .lossOfSignal(lossOfSignal),
      .lossOfSync(lossOfSync), .linkTimeout(linkTimeout), .linkResetReq(linkResetReq),
      .restartReq(restartReq), .ol1Leave(ol1Leave), .speedNegSupport(speedNegSupport),
      .pulseEnable(pulseEnable), .portState(portState), .txWord(txWord), .protoErr(protoErr),
      .protoErrCount(protoErrCount), .pulseMode(pulseMode), .leaveNormal(leaveNormal));
   far_port_model partner (.sys_clk(sys_clk), .autoOn(autoOn), .cmdCode(cmdCode),
      .txSeen(txWord), .rxCode(rxCode));

   // ----------------------------------------------------------------
   // clock and hang guard
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // the whole run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycCnt++;
      if (cycCnt == 4000) begin
         badCount++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         badCount++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc
   task automatic send(input fcp_pkg::rx_code_t c, input int n);
      cmdCode = c;
      cyc(n);
   endtask : send
   task automatic waitState(input fcp_pkg::port_state_t exp, input int maxCyc);
      for (int i = 0; i < maxCyc && portState !== exp; i++) @(negedge sys_clk);
      chk(portState, exp);
   endtask : waitState
   task automatic tally_and_finish();
      $display("comparisons=%0d mismatches=%0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic s_resetFreeze();
      chk(portState, fcp_pkg::OL1);
      chk(txWord, fcp_pkg::TX_OLS);
      chk(protoErrCount, 16'h0);
      chk(16'(leaveNormal), 16'h0);
      chk(16'(pulseMode), 16'h0);
      send(fcp_pkg::RX_LR, 8);
      chk(portState, fcp_pkg::OL1);
      ol1Leave = 1'b1;
      waitState(fcp_pkg::LR2, 6);
      chk(txWord, fcp_pkg::TX_LRR);
   endtask : s_resetFreeze
   task automatic s_activeIdles();
      int n;
      n = 0;
      cmdCode = fcp_pkg::RX_IDLE;
      waitState(fcp_pkg::AC, 8);
      while (txWord === fcp_pkg::TX_IDLE && n < 20) begin
         n++;
         cyc(1);
      end
      chk(16'(n >= 6), 16'h1);
      chk(txWord, fcp_pkg::TX_FILL);
   endtask : s_activeIdles
   task automatic s_lrrInActive();
      int pulses;
      pulses = 0;
      cmdCode = fcp_pkg::RX_LRR;
      repeat (10) begin
         cyc(1);
         if (protoErr === 1'b1) pulses++;
      end
      chk(portState, fcp_pkg::LR3);
      chk(txWord, fcp_pkg::TX_IDLE);
      chk(16'(pulses), 16'h1);
      chk(protoErrCount, 16'h1);
   endtask : s_lrrInActive
   task automatic s_olsTimer();
      cmdCode = fcp_pkg::RX_OLS;
      waitState(fcp_pkg::OL2, 8);
      chk(txWord, fcp_pkg::TX_LR);
      send(fcp_pkg::RX_OLS, 30);
      chk(portState, fcp_pkg::OL2);
      send(fcp_pkg::RX_OTHER, 15);
      chk(portState, fcp_pkg::OL2);
      waitState(fcp_pkg::OL3, 12);
      chk(txWord, fcp_pkg::TX_NOS);
   endtask : s_olsTimer
   task automatic s_offlineFailure();
      send(fcp_pkg::RX_IDLE, 8);
      chk(portState, fcp_pkg::OL3);
      cmdCode = fcp_pkg::RX_LRR;
      waitState(fcp_pkg::LF2, 8);
      chk(txWord, fcp_pkg::TX_NOS);
      send(fcp_pkg::RX_LR, 8);
      chk(portState, fcp_pkg::LF2);
      send(fcp_pkg::RX_IDLE, 8);
      chk(portState, fcp_pkg::LF2);
      cmdCode = fcp_pkg::RX_OLS;
      waitState(fcp_pkg::OL2, 8);
      cmdCode = fcp_pkg::RX_LR;
      waitState(fcp_pkg::LR2, 8);
   endtask : s_offlineFailure
   task automatic s_nosTimer();
      cmdCode = fcp_pkg::RX_NOS;
      waitState(fcp_pkg::LF1, 8);
      chk(txWord, fcp_pkg::TX_OLS);
      send(fcp_pkg::RX_NOS, 30);
      chk(portState, fcp_pkg::LF1);
      send(fcp_pkg::RX_LRR, 8);
      chk(portState, fcp_pkg::LF1);
      send(fcp_pkg::RX_OTHER, 5);
      chk(portState, fcp_pkg::LF1);
      waitState(fcp_pkg::LF2, 20);
   endtask : s_nosTimer
   task automatic s_linkReset();
      cmdCode = fcp_pkg::RX_OLS;
      waitState(fcp_pkg::OL2, 8);
      autoOn = 1'b1;
      waitState(fcp_pkg::LR3, 12);
      waitState(fcp_pkg::AC, 12);
      cyc(12);
      linkResetReq = 1'b1;
      cyc(1);
      linkResetReq = 1'b0;
      waitState(fcp_pkg::LR1, 3);
      chk(txWord, fcp_pkg::TX_LR);
      waitState(fcp_pkg::LR3, 12);
      waitState(fcp_pkg::AC, 12);
      autoOn = 1'b0;
   endtask : s_linkReset
   task automatic s_lossAndRestart();
      cmdCode = fcp_pkg::RX_OTHER;
      {pulseEnable, lossOfSignal} = 2'h3;
      cyc(3);
      chk(pulseMode, 1'b1);
      chk(portState, fcp_pkg::LF2);
      {pulseEnable, lossOfSignal} = 2'h0;
      cyc(2);
      chk(pulseMode, 1'b0);
      restartReq = 1'b1;
      cyc(1);
      restartReq = 1'b0;
      waitState(fcp_pkg::OL1, 3);
      cyc(TMO - 8);
      chk(portState, fcp_pkg::OL1);
      waitState(fcp_pkg::OL3, 15);
      {speedNegSupport, lossOfSync} = 2'h3;
      cyc(3);
      chk(leaveNormal, 1'b1);
      chk(portState, fcp_pkg::LF2);
   endtask : s_lossAndRestart

   initial begin
      {reset, lossOfSignal, lossOfSync, linkTimeout, linkResetReq} = 5'h10;
      {restartReq, ol1Leave, speedNegSupport, pulseEnable, autoOn} = 5'h0;
      cmdCode = fcp_pkg::RX_OTHER;
      badCount = 0;
      comparisons = 0;
      cycCnt = 0;
      cyc(20);
      reset = 1'b0;
      cyc(1);
      s_resetFreeze();
      s_activeIdles();
      s_lrrInActive();
      s_olsTimer();
      s_offlineFailure();
      s_nosTimer();
      s_linkReset();
      linkTimeout = 1'b1;
      cyc(2);
      linkTimeout = 1'b0;
      chk(portState, fcp_pkg::LR1);
      s_lossAndRestart();
      tally_and_finish();
   end
endmodule : link_port_primitive_sequence_fsm_tb
`default_nettype wire
